// ===== dflash_cmd_seq.sv
// data flash command sequencer: parameter array, launch, array walk and status
// What this block does
// - section erase-verify reads every word, then sets command complete
// - section erase-verify with index not two raises access error
// - invalid or odd global address raises access error for all commands
// - section running past block end raises access error
// - verify read errors set verify status, uncorrectable ones set second status
// - program word count follows index; program only unprotected area
// - program index below two or above five raises access error
// - program group past block end raises access error
// - program or erase of protected area sets protection violation, array untouched
// - program and erase are verified, verify errors set verify status, uncorrectable ones set both status bits
// - sector erase erases, verifies, completes; index not one is access error
// - command not allowed in current mode or security raises access error
// - command interrupt while complete flag and its enable are set
// - error interrupt from enabled double or single fault flags
// - wait mode leaves flash running; complete interrupt can wake
// - stop request waits until the running command finishes
module dflash_cmd_seq
  import dflash_seq_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  // parameter loading
  input  wire logic        index_wr_in,
  input  wire logic [2:0]  index_data_in,
  input  wire logic        param_wr_in,
  input  wire logic [15:0] param_data_in,
  input  wire logic        launch_in,
  // control
  input  wire logic        cmd_complete_irq_enable_in,
  input  wire logic        double_fault_irq_enable_in,
  input  wire logic        single_fault_irq_enable_in,
  input  wire logic        fault_clear_in,
  input  wire logic        status_clear_in,
  input  wire logic        cmd_allowed_in,
  input  wire logic        prot_hit_in,
  input  wire logic        stop_req_in,
  // array port
  output array_req_type    array_req_out,
  input  wire logic        array_done_in,
  input  wire logic [15:0] array_rdata_in,
  input  wire logic        ecc_single_in,
  input  wire logic        ecc_double_in,
  // status
  output logic [2:0]       param_index_out,
  output logic             cmd_complete_flag_out,
  output logic             access_error_flag_out,
  output logic             protection_violation_flag_out,
  output logic             verify_error_status_out,
  output logic             uncorrectable_error_status_out,
  output logic             double_fault_flag_out,
  output logic             single_fault_flag_out,
  output logic             cmd_irq_out,
  output logic             error_irq_out,
  output logic             stop_ack_out
);

  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_WRITE, ST_READ, ST_WAIT, ST_DONE} state_type;

  state_type       state_r, state_nxt;
  logic [15:0]     command_param_array_r [PARAM_DEPTH];
  logic [15:0]     param_nxt [PARAM_DEPTH];
  logic [2:0]      index_r, index_nxt;
  logic            complete_r, complete_nxt;
  launch_err_type  err_r, err_nxt, chk;
  verify_stat_type vstat_r, vstat_nxt;
  logic            dfault_r, dfault_nxt, sfault_r, sfault_nxt;
  logic [17:0]     addr_r, addr_nxt;
  logic [15:0]     left_r, left_nxt;
  logic [2:0]      word_r, word_nxt;
  logic [7:0]      tmr_r, tmr_nxt;
  logic [7:0]      cmd_r, cmd_nxt;
  array_req_type   req_r, req_nxt;
  logic            launch_ok;
  logic [17:0]     launch_addr;

  assign launch_addr = {command_param_array_r[0][1:0], command_param_array_r[1]};
  assign launch_ok   = launch_in && complete_r;

  dflash_launch_check u_check (
    .cmd_code_in    (command_param_array_r[0][15:8]),
    .index_in       (index_r),
    .addr_in        (launch_addr),
    .count_in       (command_param_array_r[2]),
    .cmd_allowed_in (cmd_allowed_in),
    .prot_hit_in    (prot_hit_in),
    .err_out        (chk)
  );

  dflash_irq_gate u_irq (
    .cmd_complete_flag_in       (complete_r),
    .cmd_complete_irq_enable_in (cmd_complete_irq_enable_in),
    .double_fault_flag_in       (dfault_r),
    .double_fault_irq_enable_in (double_fault_irq_enable_in),
    .single_fault_flag_in       (sfault_r),
    .single_fault_irq_enable_in (single_fault_irq_enable_in),
    .stop_req_in                (stop_req_in),
    .cmd_irq_out                (cmd_irq_out),
    .error_irq_out              (error_irq_out),
    .stop_ack_out               (stop_ack_out)
  );

  // parameter array writes ignored while a command runs
  for (genvar g = 0; g < PARAM_DEPTH; g++) begin : g_param
    always_comb begin
      param_nxt[g] = command_param_array_r[g];
      if (param_wr_in && complete_r && index_r == 3'(g)) begin
        param_nxt[g] = param_data_in;
      end
    end
    always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        command_param_array_r[g] <= 16'h0000;
      end else begin
        command_param_array_r[g] <= param_nxt[g];
      end
    end
  end

  always_comb begin
    state_nxt    = state_r;
    index_nxt    = index_r;
    complete_nxt = complete_r;
    err_nxt      = err_r;
    vstat_nxt    = vstat_r;
    dfault_nxt   = dfault_r;
    sfault_nxt   = sfault_r;
    addr_nxt     = addr_r;
    left_nxt     = left_r;
    word_nxt     = word_r;
    tmr_nxt      = tmr_r;
    cmd_nxt      = cmd_r;
    req_nxt      = req_r;
    req_nxt.req  = 1'b0;
    if (index_wr_in && complete_r) begin
      index_nxt = index_data_in;
    end
    if (status_clear_in) begin
      err_nxt = '0;
    end
    if (fault_clear_in) begin
      dfault_nxt = 1'b0;
      sfault_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        if (launch_ok && !err_r.access_error && !err_r.protection_violation) begin
          complete_nxt = 1'b0;
          vstat_nxt    = '0;
          cmd_nxt      = command_param_array_r[0][15:8];
          addr_nxt     = launch_addr;
          word_nxt     = 3'h0;
          if (chk.access_error || chk.protection_violation) begin
            err_nxt   = chk;
            state_nxt = ST_DONE;
          end else if (command_param_array_r[0][15:8] == CMD_ERASE_VERIFY_SECTION) begin
            left_nxt  = command_param_array_r[2];
            state_nxt = ST_READ;
          end else if (command_param_array_r[0][15:8] == CMD_PROGRAM_WORDS) begin
            left_nxt  = {13'h0, index_r - IDX_ADDR_LO};
            state_nxt = ST_WRITE;
          end else begin
            addr_nxt  = launch_addr & DF_SECTOR_MSK;
            left_nxt  = 16'h0080;
            state_nxt = ST_ERASE;
          end
        end
      end
      ST_ERASE: begin
        req_nxt = '{req: 1'b1, erase: 1'b1, write: 1'b0, addr: addr_r, data: 16'hFFFF};
        tmr_nxt = SECTOR_OP_CNT;
        state_nxt = ST_WAIT;
      end
      ST_WRITE: begin
        req_nxt = '{req: 1'b1, erase: 1'b0, write: 1'b1, addr: addr_r,
                    data: command_param_array_r[3'(IDX_WORD0 + word_r)]};
        tmr_nxt = WORD_OP_CNT;
        state_nxt = ST_WAIT;
      end
      ST_READ: begin
        req_nxt = '{req: 1'b1, erase: 1'b0, write: 1'b0, addr: addr_r, data: 16'h0000};
        tmr_nxt = WORD_OP_CNT;
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (tmr_r != 8'h00) begin
          tmr_nxt = tmr_r - 8'h01;
        end else if (array_done_in) begin
          if (req_r.erase) begin
            state_nxt = ST_READ;
            cmd_nxt   = CMD_ERASE_SECTOR;
          end else if (req_r.write) begin
            state_nxt = ST_READ;
          end else begin
            // read-back: erased check, or compare with programmed value
            if (ecc_single_in || ecc_double_in ||
                array_rdata_in != ((cmd_r == CMD_PROGRAM_WORDS) ?
                  command_param_array_r[3'(IDX_WORD0 + word_r)] : 16'hFFFF)) begin
              vstat_nxt.verify_error = 1'b1;
            end
            if (ecc_double_in) begin
              vstat_nxt.uncorrectable_error = 1'b1;
              dfault_nxt = 1'b1;
            end else if (ecc_single_in) begin
              sfault_nxt = 1'b1;
            end
            addr_nxt = addr_r + 18'h2;
            word_nxt = word_r + 3'h1;
            left_nxt = left_r - 16'h1;
            if (left_r == 16'h1) begin
              state_nxt = ST_DONE;
            end else if (cmd_r == CMD_PROGRAM_WORDS) begin
              state_nxt = ST_WRITE;
            end else begin
              state_nxt = ST_READ;
            end
          end
        end
      end
      ST_DONE: begin
        complete_nxt = 1'b1;
        state_nxt    = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // hardware set wins over software clear
    if (ecc_double_in && state_r == ST_WAIT && tmr_r == 8'h00 && array_done_in &&
        !req_r.write && !req_r.erase) begin
      dfault_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r    <= ST_IDLE;
      index_r    <= 3'h0;
      complete_r <= 1'b1;
      err_r      <= '0;
      vstat_r    <= '0;
      dfault_r   <= 1'b0;
      sfault_r   <= 1'b0;
      addr_r     <= 18'h0_0000;
      left_r     <= 16'h0000;
      word_r     <= 3'h0;
      tmr_r      <= 8'h00;
      cmd_r      <= 8'h00;
      req_r      <= '0;
    end else begin
      state_r    <= state_nxt;
      index_r    <= index_nxt;
      complete_r <= complete_nxt;
      err_r      <= err_nxt;
      vstat_r    <= vstat_nxt;
      dfault_r   <= dfault_nxt;
      sfault_r   <= sfault_nxt;
      addr_r     <= addr_nxt;
      left_r     <= left_nxt;
      word_r     <= word_nxt;
      tmr_r      <= tmr_nxt;
      cmd_r      <= cmd_nxt;
      req_r      <= req_nxt;
    end
  end

  assign array_req_out                  = req_r;
  assign param_index_out                = index_r;
  assign cmd_complete_flag_out          = complete_r;
  assign access_error_flag_out          = err_r.access_error;
  assign protection_violation_flag_out  = err_r.protection_violation;
  assign verify_error_status_out        = vstat_r.verify_error;
  assign uncorrectable_error_status_out = vstat_r.uncorrectable_error;
  assign double_fault_flag_out          = dfault_r;
  assign single_fault_flag_out          = sfault_r;

  a_err_skips_array: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (state_r == ST_IDLE && launch_ok && chk.access_error && !err_r.access_error
     && !err_r.protection_violation) |=> state_r == ST_DONE ##1 complete_r && err_r.access_error)
    else $error("launch error did not complete promptly");
  a_prot_no_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    err_r.protection_violation |-> !req_r.write && !req_r.erase)
    else $error("array altered under protection");
  a_cmd_irq_level: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    cmd_irq_out == (complete_r && cmd_complete_irq_enable_in))
    else $error("command irq mismatch");
  a_err_irq_level: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    error_irq_out == ((dfault_r && double_fault_irq_enable_in) || (sfault_r && single_fault_irq_enable_in)))
    else $error("error irq mismatch");
  a_stop_hold_busy: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    !complete_r |-> !stop_ack_out)
    else $error("stop granted while busy");
  a_uncorr_sets_both: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    vstat_r.uncorrectable_error |-> vstat_r.verify_error)
    else $error("uncorrectable without verify error");
  a_launch_clears_cc: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (state_r == ST_IDLE && launch_ok && !err_r.access_error && !err_r.protection_violation)
    |=> !complete_r)
    else $error("launch did not clear complete flag");
  a_bad_index_acc: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    (state_r == ST_IDLE && launch_ok && !err_r.access_error && !err_r.protection_violation
     && index_r > IDX_WORD3) |-> ##2 err_r.access_error)
    else $error("bad index not flagged");
  c_program: cover property (@(posedge clock_in) disable iff (!arst_n_in) req_r.req && req_r.write);
  c_erase: cover property (@(posedge clock_in) disable iff (!arst_n_in) req_r.req && req_r.erase);
  c_verify_err: cover property (@(posedge clock_in) disable iff (!arst_n_in) $rose(vstat_r.verify_error));

endmodule : dflash_cmd_seq

// ===== dflash_seq_pkg.sv
// shared constants and types for the data flash command sequencer
package dflash_seq_pkg;

  // command codes
  localparam logic [7:0] CMD_ERASE_VERIFY_SECTION = 8'h10;
  localparam logic [7:0] CMD_PROGRAM_WORDS        = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR         = 8'h12;

  // parameter index values
  localparam logic [2:0] IDX_ADDR_HI = 3'h0;
  localparam logic [2:0] IDX_ADDR_LO = 3'h1;
  localparam logic [2:0] IDX_WORD0   = 3'h2;
  localparam logic [2:0] IDX_WORD3   = 3'h5;
  localparam int         PARAM_DEPTH = 6;

  // data flash block placement in the 18-bit global map
  localparam logic [17:0] DF_BASE_ADDR  = 18'h0_4400;
  localparam logic [17:0] DF_LAST_ADDR  = 18'h0_53FF;
  localparam logic [17:0] DF_SECTOR_MSK = 18'h3_FF00;

  // array timing in clock cycles
  localparam int     CLK_MHZ        = 25;
  localparam int     WORD_OP_NS     = 200;
  localparam int     WORD_OP_CYC    = (WORD_OP_NS * CLK_MHZ + 999) / 1000;
  localparam int     SECTOR_ERASE_NS = 400;
  localparam int     SECTOR_ERASE_CYC = (SECTOR_ERASE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] WORD_OP_CNT   = 8'(WORD_OP_CYC);
  localparam logic [7:0] SECTOR_OP_CNT = 8'(SECTOR_ERASE_CYC);

  // zero word count, rejected as access error for section verify
  localparam logic [15:0] WORDS_RESET = 16'h0000;

  typedef struct packed {
    logic access_error;
    logic protection_violation;
  } launch_err_type;

  typedef struct packed {
    logic verify_error;
    logic uncorrectable_error;
  } verify_stat_type;

  typedef struct packed {
    logic        req;
    logic        erase;
    logic        write;
    logic [17:0] addr;
    logic [15:0] data;
  } array_req_type;

endpackage : dflash_seq_pkg

// ===== dflash_launch_check.sv
// launch-time parameter, address and protection checks
module dflash_launch_check
  import dflash_seq_pkg::*;
(
  // command image
  input  wire logic [7:0]     cmd_code_in,
  input  wire logic [2:0]     index_in,
  input  wire logic [17:0]    addr_in,
  input  wire logic [15:0]    count_in,
  // mode and protection
  input  wire logic           cmd_allowed_in,
  input  wire logic           prot_hit_in,
  // verdict
  output launch_err_type      err_out
);

  logic [18:0] end_addr;
  logic        addr_bad;
  logic [2:0]  words_m1;

  always_comb begin
    words_m1 = index_in - IDX_WORD0;
    addr_bad = (addr_in < DF_BASE_ADDR) || (addr_in > DF_LAST_ADDR) || addr_in[0];
    end_addr = {1'b0, addr_in};
    err_out  = '0;
    if (!cmd_allowed_in) begin
      err_out.access_error = 1'b1;
    end
    case (cmd_code_in)
      CMD_ERASE_VERIFY_SECTION: begin
        end_addr = {1'b0, addr_in} + {2'b00, count_in, 1'b0} - 19'h1;
        if (index_in != IDX_WORD0 || addr_bad || count_in == WORDS_RESET) begin
          err_out.access_error = 1'b1;
        end
        if (end_addr > {1'b0, DF_LAST_ADDR}) begin
          err_out.access_error = 1'b1;
        end
      end
      CMD_PROGRAM_WORDS: begin
        end_addr = {1'b0, addr_in} + {15'h0, words_m1, 1'b1};
        if (index_in < IDX_WORD0 || index_in > IDX_WORD3 || addr_bad) begin
          err_out.access_error = 1'b1;
        end else if (end_addr > {1'b0, DF_LAST_ADDR}) begin
          err_out.access_error = 1'b1;
        end
      end
      CMD_ERASE_SECTOR: begin
        if (index_in != IDX_ADDR_LO || addr_bad) begin
          err_out.access_error = 1'b1;
        end
      end
      default: begin
        err_out.access_error = 1'b1;
      end
    endcase
    if (!err_out.access_error && prot_hit_in &&
        (cmd_code_in == CMD_PROGRAM_WORDS || cmd_code_in == CMD_ERASE_SECTOR)) begin
      err_out.protection_violation = 1'b1;
    end
  end

endmodule : dflash_launch_check

// ===== dflash_irq_gate.sv
// interrupt request and low power handshake gating
module dflash_irq_gate
  import dflash_seq_pkg::*;
(
  // flags and enables
  input  wire logic cmd_complete_flag_in,
  input  wire logic cmd_complete_irq_enable_in,
  input  wire logic double_fault_flag_in,
  input  wire logic double_fault_irq_enable_in,
  input  wire logic single_fault_flag_in,
  input  wire logic single_fault_irq_enable_in,
  input  wire logic stop_req_in,
  // requests
  output logic      cmd_irq_out,
  output logic      error_irq_out,
  output logic      stop_ack_out
);

  always_comb begin
    cmd_irq_out   = cmd_complete_flag_in & cmd_complete_irq_enable_in;
    error_irq_out = (double_fault_flag_in & double_fault_irq_enable_in) |
                    (single_fault_flag_in & single_fault_irq_enable_in);
    // stop only granted once no command is in flight
    stop_ack_out  = stop_req_in & cmd_complete_flag_in;
  end

endmodule : dflash_irq_gate

// ===== test_dflash_cmd_seq.sv
// self-checking bench for the data flash command sequencer
module test_dflash_cmd_seq;
  import dflash_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic index_wr_in = 1'b0, param_wr_in = 1'b0, launch_in = 1'b0;
  logic [2:0] index_data_in = 3'h0;
  logic [15:0] param_data_in = 16'h0000;
  logic cmd_complete_irq_enable_in = 1'b1, double_fault_irq_enable_in = 1'b0;
  logic single_fault_irq_enable_in = 1'b1, fault_clear_in = 1'b0, status_clear_in = 1'b0;
  logic cmd_allowed_in = 1'b1, prot_hit_in = 1'b0, stop_req_in = 1'b0;
  logic array_done_in = 1'b1, ecc_single_in = 1'b0, ecc_double_in = 1'b0, flip = 1'b0;
  logic [15:0] last_wr = 16'hFFFF;
  logic [17:0] erase_addr = 18'h0_0000, last_addr = 18'h0_0000;
  logic [15:0] array_rdata_in;
  array_req_type array_req_out;
  logic [2:0] param_index_out;
  logic cmd_complete_flag_out, access_error_flag_out, protection_violation_flag_out;
  logic verify_error_status_out, uncorrectable_error_status_out, double_fault_flag_out;
  logic single_fault_flag_out, cmd_irq_out, error_irq_out, stop_ack_out;
  logic [5:0] flags;
  int fails = 0, num_checks = 0, cycles = 0, rd_cnt = 0, wr_cnt = 0, er_cnt = 0;

  assign flags = {access_error_flag_out, protection_violation_flag_out, verify_error_status_out,
                  uncorrectable_error_status_out, double_fault_flag_out, single_fault_flag_out};
  // read-back mirrors the last write or erase; flip forces a verify miss
  assign array_rdata_in = last_wr ^ {16{flip}};

  dflash_cmd_seq i_dflash_cmd_seq (
    .clock_in(clock_in), .arst_n_in(arst_n_in),
    .index_wr_in(index_wr_in), .index_data_in(index_data_in),
    .param_wr_in(param_wr_in), .param_data_in(param_data_in), .launch_in(launch_in),
    .cmd_complete_irq_enable_in(cmd_complete_irq_enable_in),
    .double_fault_irq_enable_in(double_fault_irq_enable_in),
    .single_fault_irq_enable_in(single_fault_irq_enable_in),
    .fault_clear_in(fault_clear_in), .status_clear_in(status_clear_in),
    .cmd_allowed_in(cmd_allowed_in), .prot_hit_in(prot_hit_in), .stop_req_in(stop_req_in),
    .array_req_out(array_req_out), .array_done_in(array_done_in),
    .array_rdata_in(array_rdata_in), .ecc_single_in(ecc_single_in), .ecc_double_in(ecc_double_in),
    .param_index_out(param_index_out), .cmd_complete_flag_out(cmd_complete_flag_out),
    .access_error_flag_out(access_error_flag_out),
    .protection_violation_flag_out(protection_violation_flag_out),
    .verify_error_status_out(verify_error_status_out),
    .uncorrectable_error_status_out(uncorrectable_error_status_out),
    .double_fault_flag_out(double_fault_flag_out), .single_fault_flag_out(single_fault_flag_out),
    .cmd_irq_out(cmd_irq_out), .error_irq_out(error_irq_out), .stop_ack_out(stop_ack_out)
  );

  always #20 clock_in = ~clock_in;

  // array stand-in: counts operations by kind
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      $display("wrong value at %0t: run did not finish", $time);
      tally_and_finish();
    end
    if (array_req_out.req === 1'b1) begin
      last_addr <= array_req_out.addr;
      if (array_req_out.write) begin
        last_wr <= array_req_out.data;
        wr_cnt <= wr_cnt + 1;
      end else if (array_req_out.erase) begin
        last_wr <= 16'hFFFF;
        erase_addr <= array_req_out.addr;
        er_cnt <= er_cnt + 1;
      end else begin
        rd_cnt <= rd_cnt + 1;
      end
    end
  end

  task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : chk_vec

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    chk_vec({5'h00, got}, {5'h00, exp}, msg);
  endtask : chk_bit

  task automatic chk_int(input int got, input int exp, input string msg);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
    end
  endtask : chk_int

  task automatic put(input logic [2:0] idx, input logic [15:0] val);
    @(negedge clock_in);
    index_wr_in = 1'b1;
    index_data_in = idx;
    @(negedge clock_in);
    index_wr_in = 1'b0;
    param_wr_in = 1'b1;
    param_data_in = val;
    @(negedge clock_in);
    param_wr_in = 1'b0;
  endtask : put

  // clear, load slots 0..nslots-1, launch, wait, judge flags and array traffic
  task automatic run(input logic [7:0] code, input logic [17:0] addr, input int nslots,
                     input logic [15:0] word, input logic [5:0] exp, input int exp_ops);
    int cyc;
    int ops;
    @(negedge clock_in);
    status_clear_in = 1'b1;
    fault_clear_in = 1'b1;
    @(negedge clock_in);
    status_clear_in = 1'b0;
    fault_clear_in = 1'b0;
    put(3'h0, {code, 6'h00, addr[17:16]});
    for (int i = 1; i < nslots; i++) put(3'(i), (i == 1) ? addr[15:0] : word);
    chk_vec({3'h0, param_index_out}, {3'h0, 3'(nslots - 1)}, "index at launch");
    rd_cnt = 0;
    wr_cnt = 0;
    er_cnt = 0;
    @(negedge clock_in);
    launch_in = 1'b1;
    @(negedge clock_in);
    launch_in = 1'b0;
    cyc = 1;
    while (cmd_complete_flag_out !== 1'b1 && cyc < 5000) begin
      @(negedge clock_in);
      cyc++;
    end
    chk_bit(cmd_complete_flag_out, 1'b1, "command completed in time");
    chk_vec(flags, exp, "status flags");
    chk_bit(cmd_irq_out, 1'b1, "command irq at completion");
    ops = (code == CMD_ERASE_VERIFY_SECTION) ? rd_cnt : (code == CMD_PROGRAM_WORDS) ? wr_cnt : er_cnt;
    chk_int(ops, exp_ops, "array operations");
    if (exp[5] | exp[4]) begin
      chk_int(rd_cnt + wr_cnt + er_cnt, 0, "array untouched on launch error");
      chk_int(int'(cyc <= 4), 1, "prompt completion on launch error");
    end
  endtask : run

  task automatic stop_test;
    array_done_in = 1'b0;
    fork
      run(8'h10, 18'h04400, 3, 16'h0001, 6'h00, 1);
      begin
        repeat (40) @(negedge clock_in);
        stop_req_in = 1'b1;
        repeat (3) @(negedge clock_in);
        chk_bit(stop_ack_out, 1'b0, "stop held off while busy");
        chk_bit(cmd_irq_out, 1'b0, "no command irq while busy");
        array_done_in = 1'b1;
      end
    join
    chk_bit(stop_ack_out, 1'b1, "stop granted after completion");
    stop_req_in = 1'b0;
  endtask : stop_test

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
    arst_n_in = 1'b1;
    chk_vec(flags, 6'h00, "flags after reset");
    chk_bit(cmd_complete_flag_out, 1'b1, "complete after reset");
    chk_bit(cmd_irq_out, 1'b1, "command irq idle");
    run(8'h10, 18'h04400, 3, 16'h0004, 6'h00, 4);
    run(8'h10, 18'h053FE, 3, 16'h0001, 6'h00, 1);
    run(8'h10, 18'h053FE, 3, 16'h0002, 6'h20, 0);
    run(8'h10, 18'h04400, 2, 16'h0004, 6'h20, 0);
    run(8'h10, 18'h00400, 3, 16'h0001, 6'h20, 0);
    run(8'h10, 18'h04401, 3, 16'h0001, 6'h20, 0);
    run(8'h11, 18'h04401, 3, 16'h0001, 6'h20, 0);
    run(8'h12, 18'h04401, 2, 16'h0000, 6'h20, 0);
    run(8'h11, 18'h04400, 6, 16'h1234, 6'h00, 4);
    chk_int(int'(last_addr), 32'h0000_4406, "last programmed word address");
    run(8'h11, 18'h04410, 3, 16'h5678, 6'h00, 1);
    run(8'h11, 18'h04420, 2, 16'h1111, 6'h20, 0);
    run(8'h11, 18'h04420, 7, 16'h1111, 6'h20, 0);
    run(8'h11, 18'h053FC, 5, 16'h2222, 6'h20, 0);
    prot_hit_in = 1'b1;
    run(8'h11, 18'h04430, 3, 16'h3333, 6'h10, 0);
    run(8'h12, 18'h04530, 2, 16'h0000, 6'h10, 0);
    prot_hit_in = 1'b0;
    flip = 1'b1;
    run(8'h11, 18'h04440, 3, 16'h00FF, 6'h08, 1);
    flip = 1'b0;
    cmd_allowed_in = 1'b0;
    run(8'h11, 18'h04450, 3, 16'h4444, 6'h20, 0);
    cmd_allowed_in = 1'b1;
    run(8'h12, 18'h04512, 3, 16'h0000, 6'h20, 0);
    run(8'h12, 18'h04512, 2, 16'h0000, 6'h00, 1);
    chk_int(int'(erase_addr), 32'h0000_4500, "sector erase base address");
    chk_int(int'(last_addr), 32'h0000_45FE, "last sector word verified");
    ecc_single_in = 1'b1;
    run(8'h10, 18'h04500, 3, 16'h0002, 6'h09, 2);
    chk_bit(error_irq_out, 1'b1, "single fault irq");
    ecc_single_in = 1'b0;
    ecc_double_in = 1'b1;
    run(8'h10, 18'h04500, 3, 16'h0002, 6'h0E, 2);
    chk_bit(error_irq_out, 1'b0, "double fault masked");
    double_fault_irq_enable_in = 1'b1;
    @(negedge clock_in);
    chk_bit(error_irq_out, 1'b1, "double fault irq");
    ecc_double_in = 1'b0;
    stop_test();
    tally_and_finish();
  end
endmodule : test_dflash_cmd_seq
